// *** logic/lpws_defs.svh ***
/*
  Timing figures and encodings of the low-power wake-up sequencer.
  Assumes inclusion by bare name from the package and the sequencer.
*/
`ifndef LPWS_DEFS_SVH
`define LPWS_DEFS_SVH
// resume latencies, system clock cycles
`define LPWS_IDLE_ACT_CYC   12'd20
`define LPWS_IDLE_SLP_CYC   12'd1050
`define LPWS_STBY_ACT_CYC   12'd100
`define LPWS_STBY_SLP_CYC   12'd1125
`define LPWS_HALT_SLP_CYC   12'd1125
`define LPWS_HALT_RAM_CYC   12'd35
// offset between decision cycle and counter load
`define LPWS_RES_OFS        12'd2
// clock hold-off before gating
`define LPWS_HOLD_CYC       7'd32
`define LPWS_HOLD_HALF_CYC  7'd64
// clock output pin drop point, inside the 32..45 window
`define LPWS_CLKOUT_LOW_CYC 7'd33
// standby pulse width, oscillator cycles
`define LPWS_STBY_RAW_OSC   7'd3
`define LPWS_STBY_QBASE_OSC 7'd2
// oscillator cycles of pll lock
`define LPWS_PLL_LOCK_OSC   131072
// low-power mode select codes
`define LPWS_MODE_IDLE      2'h0
`define LPWS_MODE_STBY      2'h1
`define LPWS_MODE_HALT      2'h2
// code fetch source codes
`define LPWS_SRC_FLASH_ACT  2'h0
`define LPWS_SRC_FLASH_SLP  2'h1
`define LPWS_SRC_RAM        2'h2
`endif

// *** logic/lpws_pkg.sv ***
/*
  Types of the low-power wake-up sequencer.
  Assumes lpws_defs.svh on the include path.
*/
package lpws_pkg;
  `include "lpws_defs.svh"

  // wake sources usable in idle mode, all active high
  typedef struct packed {
    logic enabled_irq;
    logic watchdog_wake_interrupt;
    logic external_nonmaskable_interrupt;
    logic device_reset_pin;
  } lpws_wake_t;

  // clock enables driven to the clock tree
  typedef struct packed {
    logic cpu;
    logic periph;
    logic pll;
    logic osc;
  } lpws_clk_t;

  typedef enum logic [7:0] {
    LPWS_RUN   = 8'h01,
    LPWS_IDLE  = 8'h02,
    LPWS_FLUSH = 8'h04,
    LPWS_STBY  = 8'h08,
    LPWS_HALT  = 8'h10,
    LPWS_OSCW  = 8'h20,
    LPWS_PLL   = 8'h40,
    LPWS_RES   = 8'h80
  } lpws_state_t;
endpackage : lpws_pkg

// *** logic/lpws_sequencer.sv ***
/*
  Low-power mode entry and exit sequencer: idle, standby and halt.
  Assumes all inputs synchronous to i_clk_sys; the oscillator clock is
  seen as a one-cycle tick i_osc_tick; the halt wake pin is already
  synchronised by the pad logic.
*/
// Overview of operation
// - idle resume takes 20 or 1050 cycles plus the qualifier window.
// - idle ends on enabled irq, watchdog, nmi or reset pin.
// - in standby and halt the clock output pin falls 32 to 45 cycles after the idle op.
// - in standby and halt the system clock runs 32 cycles, or 64 when halved, before gating.
// - standby gates peripheral clocks and keeps pll and watchdog.
// - standby resume takes 100 or 1125 cycles after the wake pulse.
// - after standby the waking interrupt is serviced only if enabled.
// - halt stops peripherals and pll, and the oscillator on crystal.
// - a falling wake pin edge in halt restarts the oscillator.
// - halt exit waits 131072 osc cycles of pll lock, pll used or not.
// - after lock, resume takes 1125 cycles from sleeping flash or 35 from ram or active flash.
// - halt exit re-enables clocks, then services an enabled interrupt.
`timescale 1ns/1ps
`include "lpws_defs.svh"
module lpws_sequencer
  import lpws_pkg::*;
#(
  parameter int PLL_LOCK_OSC = `LPWS_PLL_LOCK_OSC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_idle_exec,
  input  wire logic [1:0] i_mode_sel,
  input  wire logic       i_input_clock_halver,
  input  wire logic [1:0] i_fetch_src,
  input  wire logic       i_qual_en,
  input  wire logic [9:0] i_qual_window,
  input  wire logic [5:0] i_standby_wake_qualify_count,
  input  wire logic       i_osc_tick,
  input  wire logic       i_osc_stable,
  input  wire logic       i_xtal_src,
  input  wire lpws_wake_t i_wake,
  input  wire logic       i_wake_gpio_n,
  input  wire logic       i_wake_int_en,
  output lpws_clk_t       o_clk_en,
  output logic            o_clock_output_pin,
  output logic            o_resume,
  output logic            o_service_int
);

  lpws_state_t state_reg;
  lpws_state_t state_next;
  logic [6:0]  hold_reg;
  logic [6:0]  wake_cnt_reg;
  logic [11:0] res_cnt_reg;
  logic [17:0] lock_cnt_reg;
  logic        gpio_n_reg;
  logic        halt_mode_reg;
  logic        int_en_reg;

  // combinational decode
  logic        wake_any;
  logic        gpio_fall;
  logic [6:0]  hold_lim;
  logic [6:0]  stby_need;
  logic        stby_ok;
  logic        lock_done;
  logic [11:0] res_load;

  assign wake_any  = |i_wake;
  assign gpio_fall = gpio_n_reg & ~i_wake_gpio_n;
  assign hold_lim  = i_input_clock_halver ? `LPWS_HOLD_HALF_CYC
                                          : `LPWS_HOLD_CYC;
  assign stby_need = i_qual_en ? (`LPWS_STBY_QBASE_OSC +
                                  {1'b0, i_standby_wake_qualify_count})
                               : `LPWS_STBY_RAW_OSC;
  assign stby_ok   = wake_any && i_osc_tick &&
                     (wake_cnt_reg + 7'd1 >= stby_need);
  assign lock_done = (lock_cnt_reg == 18'd0) && i_osc_tick;

  // resume latency picked from state and fetch source
  always_comb begin
    res_load = `LPWS_HALT_RAM_CYC;
    unique case (state_reg)
      LPWS_IDLE: begin
        res_load = (i_fetch_src == `LPWS_SRC_FLASH_SLP) ?
                   `LPWS_IDLE_SLP_CYC : `LPWS_IDLE_ACT_CYC;
        if (i_qual_en) begin
          res_load = res_load + {2'b00, i_qual_window};
        end
      end
      LPWS_STBY: begin
        res_load = (i_fetch_src == `LPWS_SRC_FLASH_SLP) ?
                   `LPWS_STBY_SLP_CYC : `LPWS_STBY_ACT_CYC;
      end
      LPWS_PLL: begin
        res_load = (i_fetch_src == `LPWS_SRC_FLASH_SLP) ?
                   `LPWS_HALT_SLP_CYC : `LPWS_HALT_RAM_CYC;
      end
      default: res_load = `LPWS_HALT_RAM_CYC;
    endcase
  end

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPWS_RUN: begin
        if (i_idle_exec) begin
          state_next = (i_mode_sel == `LPWS_MODE_IDLE) ?
                       LPWS_IDLE : LPWS_FLUSH;
        end
      end
      LPWS_IDLE:  if (wake_any) state_next = LPWS_RES;
      LPWS_FLUSH: begin
        if (hold_reg + 7'd1 >= hold_lim) begin
          state_next = halt_mode_reg ? LPWS_HALT : LPWS_STBY;
        end
      end
      LPWS_STBY:  if (stby_ok) state_next = LPWS_RES;
      LPWS_HALT: begin
        if (gpio_fall || i_wake.device_reset_pin) begin
          state_next = LPWS_OSCW;
        end
      end
      LPWS_OSCW:  if (i_osc_stable) state_next = LPWS_PLL;
      LPWS_PLL:   if (lock_done) state_next = LPWS_RES;
      LPWS_RES:   if (res_cnt_reg == 12'd0) state_next = LPWS_RUN;
      default:    state_next = LPWS_RUN;
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) state_reg <= LPWS_RUN;
    else state_reg <= state_next;
  end

  // mode latch and hold-off counter since the idle op
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_reg      <= 7'h00;
      halt_mode_reg <= 1'b0;
    end else if (state_reg == LPWS_RUN && i_idle_exec) begin
      hold_reg      <= 7'h00;
      halt_mode_reg <= (i_mode_sel == `LPWS_MODE_HALT);
    end else if (state_reg == LPWS_FLUSH || hold_reg != 7'h00) begin
      if (hold_reg != 7'h7F) hold_reg <= hold_reg + 7'd1;
    end
  end

  // standby wake pulse width, in oscillator ticks
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) wake_cnt_reg <= 7'h00;
    else if (state_reg != LPWS_STBY || !wake_any) wake_cnt_reg <= 7'h00;
    else if (i_osc_tick && wake_cnt_reg != 7'h7F) begin
      wake_cnt_reg <= wake_cnt_reg + 7'd1;
    end
  end

  // pll lock counter, runs whether or not the pll is used
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) lock_cnt_reg <= 18'h00000;
    else if (state_reg != LPWS_PLL) begin
      lock_cnt_reg <= 18'(PLL_LOCK_OSC - 1);
    end else if (i_osc_tick && lock_cnt_reg != 18'h00000) begin
      lock_cnt_reg <= lock_cnt_reg - 18'd1;
    end
  end

  // resume latency counter
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) res_cnt_reg <= 12'h000;
    else if (state_next == LPWS_RES && state_reg != LPWS_RES) begin
      res_cnt_reg <= res_load - `LPWS_RES_OFS;
    end else if (state_reg == LPWS_RES && res_cnt_reg != 12'h000) begin
      res_cnt_reg <= res_cnt_reg - 12'd1;
    end
  end

  // wake pin edge history and interrupt enable capture
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      gpio_n_reg <= 1'b1;
      int_en_reg <= 1'b0;
    end else begin
      gpio_n_reg <= i_wake_gpio_n;
      if (state_next == LPWS_RES && state_reg != LPWS_RES) begin
        int_en_reg <= i_wake_int_en;
      end
    end
  end

  // resume and interrupt service strobes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_resume      <= 1'b0;
      o_service_int <= 1'b0;
    end else begin
      o_resume      <= (state_reg == LPWS_RES) && (res_cnt_reg == 12'd0);
      o_service_int <= (state_reg == LPWS_RES) && (res_cnt_reg == 12'd0)
                       && int_en_reg;
    end
  end

  // clock enables per mode
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_clk_en <= '{cpu: 1'b1, periph: 1'b1, pll: 1'b1, osc: 1'b1};
    end else begin
      unique case (state_next)
        LPWS_IDLE: o_clk_en <= '{cpu: 1'b0, periph: 1'b1,
                                 pll: 1'b1, osc: 1'b1};
        LPWS_STBY: o_clk_en <= '{cpu: 1'b0, periph: 1'b0,
                                 pll: 1'b1, osc: 1'b1};
        LPWS_HALT: o_clk_en <= '{cpu: 1'b0, periph: 1'b0, pll: 1'b0,
                                 osc: ~i_xtal_src};
        LPWS_OSCW: o_clk_en <= '{cpu: 1'b0, periph: 1'b0,
                                 pll: 1'b0, osc: 1'b1};
        LPWS_PLL:  o_clk_en <= '{cpu: 1'b0, periph: 1'b0,
                                 pll: 1'b1, osc: 1'b1};
        default:   o_clk_en <= '{cpu: 1'b1, periph: 1'b1,
                                 pll: 1'b1, osc: 1'b1};
      endcase
    end
  end

  // clock output pin drops at a fixed point after the idle op, in standby and halt only
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) o_clock_output_pin <= 1'b1;
    else if (state_reg == LPWS_RES || state_reg == LPWS_RUN ||
             state_reg == LPWS_IDLE) begin
      o_clock_output_pin <= 1'b1;
    end else if (hold_reg + 7'd1 == `LPWS_CLKOUT_LOW_CYC) begin
      o_clock_output_pin <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_clkout_low_window: assert property (
    $fell(o_clock_output_pin) |-> hold_reg >= 7'd32 && hold_reg <= 7'd45)
    else $error("clock output pin fell outside the window");
  a_flush_hold_clk: assert property (
    state_reg == LPWS_FLUSH && $past(state_reg) == LPWS_RUN
    |-> o_clk_en.cpu [*8])
    else $error("cpu clock gated during flush");
  a_standby_clk_set: assert property (
    state_reg == LPWS_STBY |-> !o_clk_en.periph && o_clk_en.pll)
    else $error("standby clock set wrong");
  a_halt_clk_set: assert property (
    state_reg == LPWS_HALT |-> !o_clk_en.periph && !o_clk_en.pll &&
    (o_clk_en.osc == !i_xtal_src))
    else $error("halt clock set wrong");
  a_halt_gpio_wake: assert property (
    state_reg == LPWS_HALT && gpio_fall |=> state_reg == LPWS_OSCW ##1
    o_clk_en.osc)
    else $error("wake pin edge did not start oscillator");
  a_pll_no_early: assert property (
    state_reg == LPWS_PLL && lock_cnt_reg != 18'd0 |=> state_reg == LPWS_PLL)
    else $error("left pll lock early");
  a_idle_resume_lat: assert property (
    state_reg == LPWS_IDLE && wake_any && !i_qual_en &&
    i_fetch_src != `LPWS_SRC_FLASH_SLP |-> ##20 o_resume)
    else $error("idle resume latency wrong");
  a_stby_resume_lat: assert property (
    state_reg == LPWS_STBY && stby_ok &&
    i_fetch_src != `LPWS_SRC_FLASH_SLP |-> ##100 o_resume)
    else $error("standby resume latency wrong");
  a_halt_resume_ram: assert property (
    state_reg == LPWS_PLL && lock_done &&
    i_fetch_src == `LPWS_SRC_RAM |-> ##35 o_resume)
    else $error("halt resume latency wrong");
  a_idle_wake_exit: assert property (
    state_reg == LPWS_IDLE && wake_any |=> state_reg == LPWS_RES)
    else $error("idle wake ignored");
  a_service_enabled: assert property (
    o_service_int |-> o_resume && int_en_reg)
    else $error("service without enable");
  a_mode_select: assert property (
    state_reg == LPWS_RUN && i_idle_exec |=>
    (state_reg == LPWS_IDLE) == ($past(i_mode_sel) == `LPWS_MODE_IDLE))
    else $error("mode select not followed");

  c_idle_cycle: cover property (state_reg == LPWS_IDLE ##[1:50] o_resume);
  c_stby_cycle: cover property (state_reg == LPWS_STBY ##[1:300] o_resume);
  c_halt_wake:  cover property (state_reg == LPWS_HALT ##1
                                state_reg == LPWS_OSCW);
  c_service:    cover property (o_service_int);

endmodule : lpws_sequencer

// *** verif/lpws_wake_src.sv ***
/*
  Partner model: oscillator ticks, oscillator stable flag, halt wake pin.
  Assumes i_osc_en is the sequencer's oscillator clock enable.
*/
`timescale 1ns/1ps
module lpws_wake_src (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_osc_en,
  input  wire logic i_halt_req,
  output logic      o_osc_tick,
  output logic      o_osc_stable,
  output logic      o_wake_gpio_n
);
  logic [1:0] div_reg;
  logic [2:0] start_reg;
  logic [1:0] hold_reg;

  // one oscillator tick in four system cycles
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg    <= 2'h0;
      o_osc_tick <= 1'h0;
    end else begin
      div_reg    <= div_reg + 2'h1;
      o_osc_tick <= (div_reg == 2'h3) && i_osc_en; // no ticks while off
    end
  end

  // stable five ticks after enable, raised as a tick ends
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      start_reg    <= 3'h0;
      o_osc_stable <= 1'h1;
    end else if (!i_osc_en) begin
      start_reg    <= 3'h0;
      o_osc_stable <= 1'h0;
    end else if (o_osc_tick && !o_osc_stable) begin
      start_reg <= start_reg + 3'h1;
      if (start_reg == 3'h4) o_osc_stable <= 1'h1;
    end
  end

  // wake pin held low until stable plus two ticks
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_reg      <= 2'h0;
      o_wake_gpio_n <= 1'h1;
    end else if (i_halt_req) begin
      hold_reg      <= 2'h0;
      o_wake_gpio_n <= 1'h0;
    end else if (!o_wake_gpio_n && o_osc_stable && o_osc_tick) begin
      hold_reg <= hold_reg + 2'h1;
      if (hold_reg == 2'h1) o_wake_gpio_n <= 1'h1;
    end
  end
endmodule : lpws_wake_src

// *** verif/lpws_sequencer_bench.sv ***
/*
  Self-checking bench of the wake-up sequencer: idle, standby, halt.
  Assumes the partner model drives oscillator ticks and the wake pin.
*/
`timescale 1ns/1ps
module lpws_sequencer_bench import lpws_pkg::*; ();
  localparam int LOCK = 16; // shortened pll lock count
  logic       clk, rstn, idle_exec, halver, qual_en, xtal, int_en, halt_req;
  logic [1:0] mode, src;
  logic [9:0] win;
  logic [5:0] qcnt;
  lpws_wake_t wake;
  lpws_clk_t  clk_en;
  logic       tick, stable, gpio_n, pin, resume, svc;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         mark;

  lpws_sequencer #(.PLL_LOCK_OSC(LOCK)) dut (.i_clk_sys(clk),
    .i_resetn(rstn), .i_idle_exec(idle_exec), .i_mode_sel(mode),
    .i_input_clock_halver(halver), .i_fetch_src(src), .i_qual_en(qual_en),
    .i_qual_window(win), .i_standby_wake_qualify_count(qcnt),
    .i_osc_tick(tick), .i_osc_stable(stable), .i_xtal_src(xtal),
    .i_wake(wake), .i_wake_gpio_n(gpio_n), .i_wake_int_en(int_en),
    .o_clk_en(clk_en), .o_clock_output_pin(pin), .o_resume(resume),
    .o_service_int(svc));
  lpws_wake_src wsrc (.i_clk_sys(clk), .i_resetn(rstn),
    .i_osc_en(clk_en.osc), .i_halt_req(halt_req), .o_osc_tick(tick),
    .o_osc_stable(stable), .o_wake_gpio_n(gpio_n));

  // 25 MHz clock and cycle count
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic check_range(string what, int lo, int hi, int got);
    num_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range

  function automatic int idle_lat(logic [1:0] s, logic q, logic [9:0] w);
    return (s == 2'h1 ? 1050 : 20) + (q ? int'(w) : 0);
  endfunction : idle_lat

  // idle op taken at the second edge; mark counts from it
  task automatic enter(input logic [1:0] m);
    @(posedge clk);
    mode      <= m;
    idle_exec <= 1'h1;
    @(posedge clk);
    idle_exec <= 1'h0;
    #1;
    mark = cyc;
  endtask : enter

  task automatic gate(input logic h);
    int pt, ct;
    pt = 0;
    ct = 0;
    repeat (80) begin
      @(posedge clk);
      #1;
      // counted to the edge that first samples the registered output
      if (pin === 1'h0 && pt == 0) pt = cyc - mark + 1;
      if (clk_en.cpu === 1'h0 && ct == 0) ct = cyc - mark + 1;
    end
    check_range("clock pin drop", 32, 45, pt);
    check_range("gate delay", h ? 64 : 32, h ? 66 : 34, ct);
  endtask : gate

  task automatic wait_resume(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resume !== 1'h1 && n < 3000);
    // the strobe counts at the edge that first samples it
    check_range("resume latency", lo, hi, cyc - mark + 1);
    check("service flag", int_en, svc);
    check("clocks and pin back", 5'h1F, {clk_en, pin});
  endtask : wait_resume

  task automatic idle_run(input lpws_wake_t w, input logic [1:0] s);
    int lat;
    @(posedge clk);
    qual_en <= 1'($urandom);
    win     <= 10'($urandom_range(40));
    src     <= s;
    int_en  <= 1'($urandom);
    enter(2'h0);
    repeat (3) @(posedge clk);
    check("cpu periph idle", 2'h1, {clk_en.cpu, clk_en.periph});
    wake <= w;
    @(posedge clk);
    #1;
    mark = cyc;
    // pulse of 2 cycles raw, 5 plus the window when qualified
    repeat (qual_en ? 4 + int'(win) : 1) @(posedge clk);
    wake <= '0;
    lat = idle_lat(s, qual_en, win);
    wait_resume(lat, lat);
  endtask : idle_run

  task automatic stby_run(input logic q);
    int n, need, lat;
    @(posedge clk);
    qual_en <= q;
    qcnt    <= 6'($urandom_range(5));
    halver  <= 1'($urandom);
    src     <= {1'h0, ~q};
    int_en  <= 1'($urandom);
    enter(q ? 2'h3 : 2'h1);
    gate(halver);
    check("periph pll standby", 2'h1, {clk_en.periph, clk_en.pll});
    need = q ? 2 + int'(qcnt) : 3;
    lat = q ? 100 : 1125;
    @(posedge clk);
    wake <= lpws_wake_t'(4'($urandom_range(15, 1)));
    n = 0;
    while (n < need) begin
      @(posedge clk);
      if (tick === 1'h1) n++;
    end
    mark = cyc + 1;
    wait_resume(lat, lat);
    @(posedge clk);
    wake <= '0;
  endtask : stby_run

  // wake by the pin edge, or by the reset pin held past start-up
  task automatic halt_run(input logic x, input logic rp);
    int n, lat;
    @(posedge clk);
    xtal   <= x;
    halver <= 1'h0;
    src    <= x ? 2'h2 : 2'h1;
    int_en <= 1'($urandom);
    enter(2'h2);
    gate(1'h0);
    check("halt clocks", {2'h0, ~x},
          {clk_en.periph, clk_en.pll, clk_en.osc});
    @(posedge clk);
    if (rp) wake.device_reset_pin <= 1'h1;
    else halt_req <= 1'h1;
    @(posedge clk);
    halt_req <= 1'h0;
    // the pin edge is seen one cycle after the reset pin level
    if (!rp) @(posedge clk);
    @(posedge clk);
    check("osc restart", 1'h1, clk_en.osc);
    lat = x ? 35 : 1125;
    n = 0;
    while (n < LOCK) begin
      @(posedge clk);
      if (stable === 1'h1 && tick === 1'h1) n++;
      if (rp && n == 8) wake <= '0;
    end
    mark = cyc + 1;
    wait_resume(lat, lat);
  endtask : halt_run

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // reset, then every mode and wake source
  initial begin
    {rstn, idle_exec, halver, qual_en, xtal, int_en, halt_req} = 7'h00;
    {mode, src, win, qcnt} = 20'h00000;
    wake = '0;
    void'($urandom(90));
    repeat (6) @(posedge clk);
    check("clocks in reset", 5'h1F, {clk_en, pin});
    rstn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      idle_run(lpws_wake_t'(4'(1 << i)), 2'(i));
    end
    stby_run(1'h0);
    stby_run(1'h1);
    halt_run(1'h1, 1'h0);
    halt_run(1'h0, 1'h0);
    halt_run(1'h1, 1'h1);
    stop_test();
  end
endmodule : lpws_sequencer_bench
